/* rtl/dmac_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dmac_map.svh"
module dmac_top
  import dmac_pkg::*;
#(
  parameter int ACC_W = `DMAC_ACC_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // Sign-extend a 32-bit signed product to accumulator width
  function automatic logic [ACC_W-1:0] sext32(input logic [31:0] p);
    sext32 = {{(ACC_W-32){p[31]}}, p};
  endfunction
  // Signed 16x16 multiply giving 32 bits
  function automatic logic [31:0] smul16(input logic [15:0] a, input logic [15:0] b);
    logic signed [31:0] r;
    r = $signed(a) * $signed(b);
    smul16 = r;
  endfunction

  // Software-visible registers
  logic [31:0] ctrl_q;      // Access enable
  dmac_issue_type iss_q;    // Issued instruction and operands
  dmac_result_type res_q;   // Last result
  logic done_q;             // Instruction completed
  logic skip_q;             // Condition failed
  logic [ACC_W-1:0] acc_q;  // The sole sum register
  logic [ACC_W-1:0] acc_d;
  dmac_state_type state_q;
  dmac_state_type state_d;

  // APB decode
  wire apb_acc = psel & penable;
  wire apb_wr = apb_acc & pwrite;
  wire apb_rd = apb_acc & ~pwrite;
  wire hit_ctrl = (paddr == `DMAC_REG_CTRL);
  wire hit_insn = (paddr == `DMAC_REG_INSN);
  wire hit_opa = (paddr == `DMAC_REG_OPA);
  wire hit_opb = (paddr == `DMAC_REG_OPB);
  wire hit_flags = (paddr == `DMAC_REG_FLAGS);
  wire hit_rlo = (paddr == `DMAC_REG_RES_LO);
  wire hit_rhi = (paddr == `DMAC_REG_RES_HI);
  wire hit_stat = (paddr == `DMAC_REG_STAT);
  wire hit_alo = (paddr == `DMAC_REG_ACC_LO);
  wire hit_ahi = (paddr == `DMAC_REG_ACC_HI);
  wire hit_any = hit_ctrl | hit_insn | hit_opa | hit_opb | hit_flags | hit_rlo | hit_rhi |
                 hit_stat | hit_alo | hit_ahi;
  // Writing the instruction register while idle issues it
  wire issue = apb_wr & hit_insn & (state_q == DMAC_S_IDLE);

  // Instruction field extraction
  wire [31:0] insn = iss_q.insn;
  wire [3:0] opsel = insn[`DMAC_OPSEL_HI:`DMAC_OPSEL_LO];
  wire is_mac_fmt = (insn[`DMAC_MAC_PAT_HI:`DMAC_MAC_PAT_LO] == `DMAC_MAC_PAT) &
                    (insn[11:8] == 4'h0) & insn[`DMAC_MAC_ONE_BIT];
  wire is_xfer_fmt = (insn[`DMAC_XFER_PAT_HI:`DMAC_XFER_PAT_LO] == `DMAC_XFER_PAT) &
                     (insn[11:8] == 4'h0) & (insn[3] == 1'b0);
  wire mac_sole_sum_register = (insn[`DMAC_MAC_ACC_HI:`DMAC_MAC_ACC_LO] == 3'h0);
  wire xfer_sole_sum_register = (insn[`DMAC_XFER_ACC_HI:`DMAC_XFER_ACC_LO] == 3'h0);
  wire xfer_read = insn[`DMAC_DIR_BIT];
  // Operand naming: opa is multiplier / high transfer, opb is multiplicand / low transfer
  wire [31:0] mplier = iss_q.opa;
  wire [31:0] mcand = iss_q.opb;

  // Classify the instruction
  dmac_kind_type kind;
  always_comb begin
    kind = DMAC_K_NONE;
    if (is_mac_fmt && mac_sole_sum_register) begin
      if (opsel == `DMAC_OP_WORD) begin
        kind = DMAC_K_WORD;
      end else if (opsel == `DMAC_OP_DUAL) begin
        kind = DMAC_K_DUAL;
      end else if (opsel[3:2] == `DMAC_OP_HALF_TOP) begin
        kind = DMAC_K_HALF;
      end
    end else if (is_xfer_fmt && xfer_sole_sum_register) begin
      kind = DMAC_K_XFER;
    end
  end

  // Condition check against the core's flags
  logic cond_ok;
  dmac_cond u_cond (
    .cond(insn[`DMAC_COND_HI:`DMAC_COND_LO]),
    .flags(iss_q.flags),
    .pass(cond_ok)
  );
  wire enabled = ctrl_q[`DMAC_CTRL_EN_BIT];

  // Products
  wire signed [63:0] word_prod = $signed(mplier) * $signed(mcand);
  wire [31:0] low_prod = smul16(mplier[15:0], mcand[15:0]);
  wire [31:0] high_prod = smul16(mplier[31:16], mcand[31:16]);
  wire [15:0] half_a = insn[`DMAC_X_BIT] ? mcand[31:16] : mcand[15:0];
  wire [15:0] half_b = insn[`DMAC_Y_BIT] ? mplier[31:16] : mplier[15:0];
  wire [31:0] half_prod = smul16(half_a, half_b);

  // Execute step: only a passed, enabled, defined instruction changes the accumulator
  wire do_exec = (state_q == DMAC_S_EXEC) & enabled & cond_ok;
  always_comb begin
    acc_d = acc_q;
    if (do_exec) begin
      case (kind)
        DMAC_K_WORD: acc_d = acc_q + word_prod[ACC_W-1:0];
        DMAC_K_DUAL: acc_d = acc_q + sext32(low_prod) + sext32(high_prod);
        DMAC_K_HALF: acc_d = acc_q + sext32(half_prod);
        DMAC_K_XFER: begin
          if (!xfer_read) begin
            acc_d = {iss_q.opa[7:0], iss_q.opb};
          end
        end
        default: acc_d = acc_q;
      endcase
    end
  end

  // Sequencer
  always_comb begin
    case (state_q)
      DMAC_S_IDLE: state_d = issue ? DMAC_S_EXEC : DMAC_S_IDLE;
      DMAC_S_EXEC: state_d = DMAC_S_DONE;
      DMAC_S_DONE: state_d = DMAC_S_IDLE;
      default: state_d = DMAC_S_IDLE;
    endcase
  end

  // Readback values
  wire [31:0] rd_hi = {{(32-(ACC_W-32)){acc_q[ACC_W-1]}}, acc_q[ACC_W-1:32]};
  wire [31:0] rd_lo = acc_q[31:0];
  wire exec_read = do_exec & (kind == DMAC_K_XFER) & xfer_read;
  wire exec_undef = (state_q == DMAC_S_EXEC) & ~enabled;

  // State and accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= DMAC_S_IDLE;
      acc_q <= '0;
    end else begin
      state_q <= state_d;
      acc_q <= acc_d;
    end
  end

  // Result and status capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q <= '0;
      done_q <= 1'b0;
      skip_q <= 1'b0;
    end else if (state_q == DMAC_S_EXEC) begin
      res_q.undef_exc <= exec_undef;
      res_q.wr_regs <= exec_read;
      res_q.lo <= exec_read ? rd_lo : res_q.lo;
      res_q.hi <= exec_read ? rd_hi : res_q.hi;
      done_q <= 1'b1;
      skip_q <= enabled & ~cond_ok;
    end else if (issue) begin
      done_q <= 1'b0;
    end
  end

  // Software register writes; the flags register changes only here, on a software write to it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `DMAC_CTRL_RST;
      iss_q <= '0;
    end else if (apb_wr) begin
      if (hit_ctrl) ctrl_q <= pwdata;
      if (issue) iss_q.insn <= pwdata;
      if (hit_opa) iss_q.opa <= pwdata;
      if (hit_opb) iss_q.opb <= pwdata;
      if (hit_flags) iss_q.flags <= pwdata[3:0];
    end
  end

  // APB read mux
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_ctrl) rdata = {31'h0000_0000, ctrl_q[`DMAC_CTRL_EN_BIT]};
    if (hit_insn) rdata = iss_q.insn;
    if (hit_opa) rdata = iss_q.opa;
    if (hit_opb) rdata = iss_q.opb;
    if (hit_flags) rdata = {28'h000_0000, iss_q.flags};
    if (hit_rlo) rdata = res_q.lo;
    if (hit_rhi) rdata = res_q.hi;
    // Status: bit 3 marks that the last instruction returned the sum register
    if (hit_stat) rdata = {28'h000_0000, res_q.wr_regs, skip_q, done_q, res_q.undef_exc};
    if (hit_alo) rdata = rd_lo;
    if (hit_ahi) rdata = rd_hi;
  end
  // Zero-wait answer; unmapped addresses return an error
  assign pready = 1'b1;
  assign pslverr = apb_acc & ~hit_any;
  assign prdata = (apb_rd & hit_any) ? rdata : 32'h0000_0000;

  // Assertions
  // Reference products from sign-extended operands, formed apart from the datapath
  wire [63:0] ref_word = {{32{mplier[31]}}, mplier} * {{32{mcand[31]}}, mcand};
  wire [31:0] ref_lo = {{16{mplier[15]}}, mplier[15:0]} * {{16{mcand[15]}}, mcand[15:0]};
  wire [31:0] ref_hi = {{16{mplier[31]}}, mplier[31:16]} * {{16{mcand[31]}}, mcand[31:16]};
  wire [31:0] ref_cand = mcand >> {opsel[1], 4'h0};
  wire [31:0] ref_plier = mplier >> {opsel[0], 4'h0};
  wire [31:0] ref_half = {{16{ref_plier[15]}}, ref_plier[15:0]} * {{16{ref_cand[15]}}, ref_cand[15:0]};

  // Disabled access leaves the sum register alone and reports the exception
  undef_no_acc_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == DMAC_S_EXEC && !enabled) |=> (acc_q == $past(acc_q)) && res_q.undef_exc)
    else $error("disabled access changed accumulator");

  // Enabled access never reports the exception
  enabled_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == DMAC_S_EXEC && enabled) |=> !res_q.undef_exc)
    else $error("enabled access raised exception");

  // Failed condition holds the sum register
  cond_fail_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == DMAC_S_EXEC && !cond_ok) |=> acc_q == $past(acc_q))
    else $error("failed condition changed accumulator");

  // Failed condition is reported in status
  skip_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == DMAC_S_EXEC && enabled && !cond_ok) |=> skip_q)
    else $error("failed condition not reported");

  // Full-word product truncated and added modulo the sum width
  word_sum_a: assert property (@(posedge pclk) disable iff (!presetn)
    (do_exec && kind == DMAC_K_WORD) |=> acc_q == $past(acc_q + ref_word[ACC_W-1:0]))
    else $error("word multiply-add wrong");

  // Low halves multiplied as signed values
  dual_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (do_exec && kind == DMAC_K_DUAL) |-> low_prod == ref_lo)
    else $error("dual low product wrong");

  // Upper halves multiplied as signed values
  dual_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    (do_exec && kind == DMAC_K_DUAL) |-> high_prod == ref_hi)
    else $error("dual high product wrong");

  // Both packed products sign-extended and added
  dual_sum_a: assert property (@(posedge pclk) disable iff (!presetn)
    (do_exec && kind == DMAC_K_DUAL) |=>
      acc_q == $past(acc_q + {{(ACC_W-32){ref_lo[31]}}, ref_lo} + {{(ACC_W-32){ref_hi[31]}}, ref_hi}))
    else $error("dual multiply-add wrong");

  // One signed halfword product added
  half_sum_a: assert property (@(posedge pclk) disable iff (!presetn)
    (do_exec && kind == DMAC_K_HALF) |=> acc_q == $past(acc_q + {{(ACC_W-32){ref_half[31]}}, ref_half}))
    else $error("halfword multiply-add wrong");

  // Halves picked by the x and y bits
  half_pick_a: assert property (@(posedge pclk) disable iff (!presetn)
    (do_exec && kind == DMAC_K_HALF) |-> half_prod == ref_half)
    else $error("halfword selection wrong");

  // Undefined operation codes leave the sum register alone
  bad_op_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == DMAC_S_EXEC && is_mac_fmt && opsel != 4'h0 && opsel != 4'h8 && opsel[3:2] != 2'h3) |=>
      acc_q == $past(acc_q))
    else $error("undefined operation acted");

  // Nonzero accumulator select on a multiply does nothing
  bad_acc_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == DMAC_S_EXEC && is_mac_fmt && !mac_sole_sum_register) |=> acc_q == $past(acc_q))
    else $error("nonzero accumulator select acted");

  // Inbound transfer fills the sum register from both operands
  load_sum_a: assert property (@(posedge pclk) disable iff (!presetn)
    (do_exec && kind == DMAC_K_XFER && !xfer_read) |=> acc_q == {$past(iss_q.opa[7:0]), $past(iss_q.opb)})
    else $error("inbound transfer wrong");

  // Outbound high word is the sign-extended top byte
  read_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
    exec_read |=> res_q.hi == {{(64-ACC_W){$past(acc_q[ACC_W-1])}}, $past(acc_q[ACC_W-1:32])})
    else $error("outbound transfer wrong");

  // Outbound low word mirrors the low 32 bits
  read_lo_a: assert property (@(posedge pclk) disable iff (!presetn)
    exec_read |=> res_q.lo == $past(acc_q[31:0]))
    else $error("outbound low word wrong");

  // Outbound transfer keeps the sum register and flags a register result
  read_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    exec_read |=> (acc_q == $past(acc_q)) && res_q.wr_regs)
    else $error("outbound transfer direction wrong");

  // Inbound transfer returns nothing to the core
  load_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    (do_exec && kind == DMAC_K_XFER && !xfer_read) |=> !res_q.wr_regs)
    else $error("inbound transfer returned registers");

  // Nonzero accumulator select on a transfer does nothing
  xfer_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == DMAC_S_EXEC && is_xfer_fmt && !xfer_sole_sum_register) |=> acc_q == $past(acc_q))
    else $error("nonzero transfer select acted");

  // Sum register persists outside the execute cycle
  idle_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q != DMAC_S_EXEC) |=> acc_q == $past(acc_q))
    else $error("accumulator changed outside execute");

  // Condition flags change only by a software write
  flags_kept_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(apb_wr && hit_flags) |=> $stable(iss_q.flags))
    else $error("flags changed by instruction");

  // An instruction written while busy is ignored
  busy_insn_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q != DMAC_S_IDLE && apb_wr && hit_insn) |=> $stable(iss_q.insn))
    else $error("instruction accepted while busy");
endmodule
`default_nettype wire

/* rtl/dmac_map.svh */
`ifndef DMAC_MAP_SVH
`define DMAC_MAP_SVH
// Accumulator geometry
`define DMAC_ACC_W 40
// Instruction field positions
`define DMAC_COND_HI 31
`define DMAC_COND_LO 28
`define DMAC_MAC_PAT_HI 27
`define DMAC_MAC_PAT_LO 20
`define DMAC_MAC_PAT 8'hE2
`define DMAC_XFER_PAT_HI 27
`define DMAC_XFER_PAT_LO 21
`define DMAC_XFER_PAT 7'h62
`define DMAC_DIR_BIT 20
`define DMAC_OPSEL_HI 19
`define DMAC_OPSEL_LO 16
`define DMAC_X_BIT 17
`define DMAC_Y_BIT 16
`define DMAC_MAC_ACC_HI 7
`define DMAC_MAC_ACC_LO 5
`define DMAC_MAC_ONE_BIT 4
`define DMAC_XFER_ACC_HI 2
`define DMAC_XFER_ACC_LO 0
// Operation select codes
`define DMAC_OP_WORD 4'h0
`define DMAC_OP_DUAL 4'h8
`define DMAC_OP_HALF_TOP 2'h3
// APB register offsets (byte addresses)
`define DMAC_REG_CTRL 12'h000
`define DMAC_REG_INSN 12'h004
`define DMAC_REG_OPA 12'h008
`define DMAC_REG_OPB 12'h00C
`define DMAC_REG_FLAGS 12'h010
`define DMAC_REG_RES_LO 12'h014
`define DMAC_REG_RES_HI 12'h018
`define DMAC_REG_STAT 12'h01C
`define DMAC_REG_ACC_LO 12'h020
`define DMAC_REG_ACC_HI 12'h024
// Field positions in control and status
`define DMAC_CTRL_EN_BIT 0
`define DMAC_STAT_UNDEF_BIT 0
`define DMAC_STAT_DONE_BIT 1
`define DMAC_STAT_SKIP_BIT 2
`define DMAC_STAT_RD_BIT 3
// Reset values
`define DMAC_CTRL_RST 32'h0000_0000
`endif

/* rtl/dmac_pkg.sv */
`default_nettype none
package dmac_pkg;
  // Decoded instruction class
  typedef enum logic [4:0] {
    DMAC_K_NONE = 5'h01,
    DMAC_K_WORD = 5'h02,
    DMAC_K_DUAL = 5'h04,
    DMAC_K_HALF = 5'h08,
    DMAC_K_XFER = 5'h10
  } dmac_kind_type;
  // Execute sequencer states
  typedef enum logic [2:0] {
    DMAC_S_IDLE = 3'h1,
    DMAC_S_EXEC = 3'h2,
    DMAC_S_DONE = 3'h4
  } dmac_state_type;
  // Issued instruction with operand values
  typedef struct packed {
    logic [31:0] insn;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [3:0] flags;
  } dmac_issue_type;
  // Result returned to the core
  typedef struct packed {
    logic [31:0] lo;
    logic [31:0] hi;
    logic undef_exc;
    logic wr_regs;
  } dmac_result_type;
endpackage
`default_nettype wire

/* rtl/dmac_cond.sv */
`timescale 1ns/1ps
`default_nettype none
// Condition-code evaluator: flags are {n,z,c,v}
module dmac_cond (
  input wire logic [3:0] cond,
  input wire logic [3:0] flags,
  output logic pass
);
  // Individual flags
  wire n = flags[3];
  wire z = flags[2];
  wire c = flags[1];
  wire v = flags[0];
  // Base predicate from the upper three bits, inverted by bit 0
  logic base;
  always_comb begin
    case (cond[3:1])
      3'h0: base = z;
      3'h1: base = c;
      3'h2: base = n;
      3'h3: base = v;
      3'h4: base = c & ~z;
      3'h5: base = (n == v);
      3'h6: base = ~z & (n == v);
      default: base = 1'b1;
    endcase
  end
  // The always code with bit 0 set is kept as always
  assign pass = (cond == 4'hF) ? 1'b1 : (base ^ cond[0]);
endmodule
`default_nettype wire

/* tb/dmac_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host core side: drives the register bus and encodes coprocessor instructions
module dmac_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Bus starts idle
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // Setup, access held until pready, then one idle cycle before the next request
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data flips so a stale value is never mistaken for a live one
    pwdata <= ~d;
    @(posedge pclk);
  endtask
  // Multiply-accumulate word; register numbers are arbitrary, operands come over the bus
  function automatic logic [31:0] mac(input logic [3:0] c, input logic [3:0] op, input logic [2:0] a);
    return {c, 8'hE2, op, 4'h1, 4'h0, a, 1'b1, 4'h2};
  endfunction
  // Accumulator transfer word; reserved field kept at zero
  function automatic logic [31:0] xf(input logic [3:0] c, input logic l, input logic [2:0] a);
    return {c, 7'h62, l, 4'h1, 4'h2, 4'h0, 4'h0, 1'b0, a};
  endfunction
endmodule
`default_nettype wire

/* tb/dmac_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dmac_map.svh"
module dmac_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, a, b;
  logic [39:0] acc_e; // Expected accumulator
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  // 10 MHz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  dmac_top dmac_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  dmac_host_model dmac_host_model_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    dmac_host_model_i.xfer(1'b1, ad, d, q, e);
  endtask
  task automatic rd(input logic [11:0] ad);
    dmac_host_model_i.xfer(1'b0, ad, 32'h0000_0000, q, e);
  endtask
  // Operands and flags first, then issue; the sequencer needs three cycles
  task automatic run(input logic [31:0] insn, input logic [3:0] f);
    wr(`DMAC_REG_OPA, a);
    wr(`DMAC_REG_OPB, b);
    wr(`DMAC_REG_FLAGS, {28'h0, f});
    wr(`DMAC_REG_INSN, insn);
    repeat (3) @(posedge pclk);
  endtask
  // Live accumulator against the expectation, high part sign-extended
  task automatic chk_acc();
    rd(`DMAC_REG_ACC_LO);
    chk(q, acc_e[31:0]);
    rd(`DMAC_REG_ACC_HI);
    chk(q, {{24{acc_e[39]}}, acc_e[39:32]});
  endtask
  // Signed 16x16 product widened to the accumulator
  function automatic logic [39:0] sx(input logic [15:0] p, input logic [15:0] r);
    logic signed [31:0] m;
    m = $signed(p) * $signed(r);
    return {{8{m[31]}}, m};
  endfunction
  // Signed 32x32 product truncated to the accumulator
  function automatic logic [39:0] wx(input logic [31:0] p, input logic [31:0] r);
    logic signed [63:0] m;
    m = $signed({{32{p[31]}}, p}) * $signed({{32{r[31]}}, r});
    return m[39:0];
  endfunction
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    presetn = 1'b0;
    acc_e = 40'h0;
    a = 32'hFFFF_FFFD;
    b = 32'h7FFF_FFFF;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`DMAC_REG_CTRL);
    chk(q, `DMAC_CTRL_RST);
    chk_acc();
    rd(12'h040);
    chk({31'h0, e}, 32'h1);
    $display("Test reset done");
    // Disabled unit refuses and flags an exception
    run(dmac_host_model_i.mac(4'hE, 4'h0, 3'h0), 4'h0);
    rd(`DMAC_REG_STAT);
    chk(q, 32'h0000_0003);
    chk_acc();
    wr(`DMAC_REG_CTRL, 32'h0000_0001);
    $display("Test disabled done");
    // Inbound then outbound transfer
    a = 32'hA5A5_5A80;
    b = 32'hDEAD_BEEF;
    run(dmac_host_model_i.xf(4'hE, 1'b0, 3'h0), 4'h0);
    acc_e = 40'h80_DEAD_BEEF;
    chk_acc();
    rd(`DMAC_REG_STAT);
    chk(q, 32'h0000_0002);
    run(dmac_host_model_i.xf(4'hE, 1'b1, 3'h0), 4'h0);
    rd(`DMAC_REG_RES_LO);
    chk(q, 32'hDEAD_BEEF);
    rd(`DMAC_REG_RES_HI);
    chk(q, 32'hFFFF_FF80);
    rd(`DMAC_REG_STAT);
    chk(q, 32'h0000_000A);
    $display("Test transfer done");
    // Word, dual and all four halfword selections
    a = 32'hFFFF_FFFD;
    b = 32'h7FFF_FFFF;
    run(dmac_host_model_i.mac(4'hE, `DMAC_OP_WORD, 3'h0), 4'h0);
    acc_e = acc_e + wx(a, b);
    chk_acc();
    a = 32'h8000_0003;
    b = 32'h7FFF_FFFE;
    run(dmac_host_model_i.mac(4'hE, `DMAC_OP_DUAL, 3'h0), 4'h0);
    acc_e = acc_e + sx(a[15:0], b[15:0]) + sx(a[31:16], b[31:16]);
    chk_acc();
    a = 32'h8001_7FFF;
    b = 32'hFFFE_0003;
    for (int xy = 0; xy < 4; xy++) begin
      run(dmac_host_model_i.mac(4'hE, {2'b11, 2'(xy)}, 3'h0), 4'h0);
      acc_e = acc_e + sx(xy[0] ? a[31:16] : a[15:0], xy[1] ? b[31:16] : b[15:0]);
      chk_acc();
    end
    $display("Test multiply done");
    // Failed condition, bad select, bad op code: all leave the accumulator alone
    run(dmac_host_model_i.mac(4'h0, `DMAC_OP_WORD, 3'h0), 4'h0);
    rd(`DMAC_REG_STAT);
    chk(q, 32'h0000_0006);
    run(dmac_host_model_i.mac(4'hE, `DMAC_OP_WORD, 3'h1), 4'h0);
    run(dmac_host_model_i.mac(4'hE, 4'h4, 3'h0), 4'h0);
    run(dmac_host_model_i.xf(4'hE, 1'b0, 3'h2), 4'h0);
    chk_acc();
    run(dmac_host_model_i.mac(4'h0, `DMAC_OP_WORD, 3'h0), 4'h4);
    acc_e = acc_e + wx(a, b);
    chk_acc();
    rd(`DMAC_REG_FLAGS);
    chk(q, 32'h0000_0004);
    $display("Test refusal done");
    end_of_test();
  end
endmodule
`default_nettype wire
